// ===== dse_sense_top.sv
`include "dse_cfg.svh"

// Contract
// - count field error sets checks, ends operation
// - index before write completes sets overrun
// - reading back overrun record never sets it
// - end of cylinder mid chain sets bit
// - illegal chains set invalid sequence, reject
// - index point turns index latch on
// - ha/data read, write, sense, control, unchain clear
// - second index on single-track search: no record
// - space count no mark, missing ha/r0
// - read data commands clear at data field
// - mask violation sets protected; write rejects
// - equal flag bit 0 means missing mark
// - missing mark sets bit and data check
// - overflow incomplete plus its cause bit
// - drive malfunctions set unsafe
// - lost or gained write bit: serdes check
// - microprogram impossible state sets alu check
// - status line without selection: unselected status
// - sense command sends all six bytes
module dse_sense_top #(
    parameter int ST_W       = 8,    // drive status lines
    parameter int HEAD_W     = 10,   // head select lines
    parameter int MOD_W      = 8,    // drive module select lines
    parameter bit OVF_OPTION = 1'b1  // record overflow feature fitted
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clkEn,
    input  wire logic             cmdStart,
    input  dse_pkg::dse_op_e      cmdOp,
    input  wire logic             cmdMultitrack,
    input  wire logic             chainActive,
    input  wire logic             countFieldErr,
    input  wire logic             writeActive,
    input  wire logic             endOfCylHit,
    input  wire logic             headSwitchReq,
    input  wire logic             invalidSeqHit,
    input  wire logic             haFieldRead,
    input  wire logic             dataFieldRead,
    input  wire logic             addrMarkFound,
    input  wire logic             haR0Missing,
    input  wire logic             maskViolation,
    input  wire logic             maskWriteViol,
    input  wire logic             flagValid,
    input  wire logic             flagBit0,
    input  wire logic             ovfEvent,
    input  dse_pkg::dse_ovf_e     ovfCause,
    input  wire logic             serdesErr,
    input  wire logic             aluErr,
    input  wire logic             idxPin,
    input  wire logic [ST_W-1:0]  statusPins,
    input  wire logic [HEAD_W-1:0] headSelPins,
    input  wire logic [MOD_W-1:0] moduleSelPins,
    input  wire logic             readGatePin,
    input  wire logic             writeGatePin,
    input  wire logic             writeDriverPin,
    input  wire logic             eraseGatePin,
    input  wire logic             eraseDriverPin,
    output logic [7:0]            senseData,
    output logic                  senseValid,
    output logic [2:0]            senseIndex,
    output logic                  senseLast,
    output logic                  endOperation,
    output logic                  indexPassed,
    output logic [7:0]            senseConditionSecondByte,
    output logic [7:0]            senseEquipmentThirdByte
);
    import dse_pkg::*;

    // filtered pin vector layout, index in bit 0
    localparam int ST_LO = 1;
    localparam int HD_LO = ST_LO + ST_W;
    localparam int MD_LO = HD_LO + HEAD_W;
    localparam int GT_LO = MD_LO + MOD_W;
    localparam int PIN_W = GT_LO + 5;

    typedef struct packed {
        logic [PIN_W-1:0] sync1;     // first stage, read by sync2 only
        logic [PIN_W-1:0] sync2;
        logic [PIN_W-1:0] sync3;
        logic [PIN_W-1:0] pinF;      // agreed pin levels
        logic             idxPrev;   // for index edge
        logic             chainPrev; // for chain break detection
        logic [7:0]       b0;        // sense byte 0 (bits we own)
        logic [7:0]       b1;        // sense byte 1
        logic [7:0]       b2;        // sense byte 2
        logic             maskSeen;  // file mask already set in chain
        logic             seekSeen;  // seek done in chain
        logic             writeSeen; // write done in chain
        logic             haPassed;  // home address passed this command
        logic             amSeen;    // address mark found this command
        logic             lastFlag;  // flag bit 0 of previous record
        logic             haveFlag;  // lastFlag is meaningful
        dse_op_e          op;        // command in effect
        logic             mt;        // its multitrack bit
        dse_send_e        send;
        logic [2:0]       idx;
        logic [2:0]       outIdx;    // index of the byte now in data
        logic [7:0]       data;
        logic             valid;
        logic             last;
        logic             endOp;
    } dse_state_s;

    dse_state_s st;   // registered state
    dse_state_s stD;  // next state

    dse_ixp_if ixp ();  // link to the index tracker

    // write-type commands, used for overrun, chain rules and latch clear
    function automatic logic isWrite(input dse_op_e op);
        return op inside {OP_WRITE_R0, OP_WRITE_CKD, OP_WRITE_KD,
                          OP_WRITE_D, OP_WRITE_OTHER};
    endfunction

    // read or search commands
    function automatic logic isReadSearch(input dse_op_e op);
        return op inside {OP_READ_HA, OP_READ_R0, OP_READ_CKD,
                          OP_READ_COUNT, OP_SEARCH_ID, OP_SEARCH_OTHER};
    endfunction

    logic             indexEdge;    // rising edge of the agreed index
    logic             chainBroken;  // chaining dropped this cycle
    logic             clrCmd;       // write, sense, seek, set mask or control command
    logic             startSense;
    logic             overrunOp;
    logic [HEAD_W-1:0] headF;
    logic [MOD_W-1:0] modF;
    logic [ST_W-1:0]  statF;
    logic [4:0]       gateF;        // erase drv, erase gate, wr drv, wr, rd
    logic [7:0]       set0;
    logic [7:0]       set1;
    logic [7:0]       set2;
    logic             clrSense;

    assign headF       = st.pinF[HD_LO +: HEAD_W];
    assign modF        = st.pinF[MD_LO +: MOD_W];
    assign statF       = st.pinF[ST_LO +: ST_W];
    assign gateF       = st.pinF[GT_LO +: 5];
    assign indexEdge   = st.pinF[0] & ~st.idxPrev;
    assign chainBroken = st.chainPrev & ~chainActive;
    assign startSense  = cmdStart & (cmdOp == OP_SENSE);
    assign clrCmd      = cmdStart & (isWrite(cmdOp) | (cmdOp == OP_SENSE) |
                         (cmdOp inside {OP_SEEK, OP_SET_MASK, OP_CONTROL}));
    // read-back of a short record is a read, so it never counts here
    assign overrunOp   = isWrite(st.op) | (st.op == OP_SPACE_COUNT);

    // tracker hookup; data field read also covers read ckd/kd/data
    assign ixp.ce        = clkEn;
    assign ixp.indexEdge = indexEdge;
    assign ixp.clrLatch  = haFieldRead | dataFieldRead | clrCmd
                         | chainBroken;
    assign ixp.nrfCheck  = isReadSearch(st.op) & ~st.mt
                         & ~(st.op inside {OP_READ_HA, OP_READ_R0});

    dse_index_track u_track (
        .clk   (clk),
        .reset (reset),
        .ixp   (ixp)
    );

    // collect every set event of this cycle
    always_comb begin
        set0 = '0;
        set1 = '0;
        set2 = '0;
        if (countFieldErr) begin
            set1[`DSE_B1_COUNT_CHECK] = 1'b1;
            set0[`DSE_B0_DATA_CHECK]  = 1'b1;
        end
        if (indexEdge && writeActive && overrunOp) begin
            set1[`DSE_B1_TRACK_OVERRUN] = 1'b1;
        end
        if (endOfCylHit && chainActive) begin
            set1[`DSE_B1_END_OF_CYL] = 1'b1;
        end
        // illegal chains; the set file mask and space count checks
        // look at what came before in the same chain
        if ((cmdStart && cmdOp == OP_SET_MASK && st.maskSeen) ||
            (cmdStart && cmdOp == OP_SPACE_COUNT && st.writeSeen) ||
            (headSwitchReq && !st.seekSeen) || invalidSeqHit) begin
            set1[`DSE_B1_INVALID_SEQ] = 1'b1;
            set0[`DSE_B0_CMD_REJECT]  = 1'b1;
        end
        if (ixp.nrfHit) begin
            set1[`DSE_B1_NO_RECORD] = 1'b1;
        end
        if (indexEdge && st.op == OP_SPACE_COUNT && st.haPassed &&
            !st.amSeen) begin
            set1[`DSE_B1_NO_RECORD] = 1'b1;
        end
        if (haR0Missing) begin
            set1[`DSE_B1_NO_RECORD]  = 1'b1;
            set1[`DSE_B1_MISSING_AM] = 1'b1;
        end
        // reads and searches only count when multitrack
        if (maskViolation && (st.op == OP_SEEK || isWrite(st.op) ||
            (isReadSearch(st.op) && st.mt))) begin
            set1[`DSE_B1_FILE_PROT] = 1'b1;
            if (maskWriteViol) begin
                set0[`DSE_B0_CMD_REJECT] = 1'b1;
            end
        end
        // search id is allowed to skip over the gap silently
        if (flagValid && st.haveFlag && (flagBit0 == st.lastFlag) &&
            st.op != OP_SEARCH_ID) begin
            set1[`DSE_B1_MISSING_AM] = 1'b1;
            set0[`DSE_B0_DATA_CHECK] = 1'b1;
        end
        if (OVF_OPTION && ovfEvent) begin
            set1[`DSE_B1_OVF_INCOMPLETE] = 1'b1;
            case (ovfCause)
                OVF_BAD_TRACK, OVF_FROM_ALT: begin
                    set0[`DSE_B0_TRACK_COND] = 1'b1;
                end
                OVF_PROTECTED: begin
                    set1[`DSE_B1_FILE_PROT] = 1'b1;
                end
                OVF_WRONG_HEAD: begin
                    set0[`DSE_B0_SEEK_CHECK] = 1'b1;
                end
                OVF_END_CYL: begin
                    set1[`DSE_B1_END_OF_CYL] = 1'b1;
                end
                default: begin
                    set0[`DSE_B0_TRACK_COND] = 1'b1;
                end
            endcase
        end
        // unsafe: several heads, read with write, gate/driver disagree
        if (((headF & (headF - {{(HEAD_W-1){1'b0}}, 1'b1})) != '0) ||
            (gateF[0] && gateF[1]) || (gateF[1] != gateF[2]) ||
            (gateF[3] != gateF[4])) begin
            set2[`DSE_B2_UNSAFE] = 1'b1;
        end
        if (serdesErr) begin
            set2[`DSE_B2_SERDES] = 1'b1;
        end
        if (aluErr) begin
            set2[`DSE_B2_ALU] = 1'b1;
        end
        if ((statF != '0) && (modF == '0)) begin
            set2[`DSE_B2_UNSELECTED] = 1'b1;
        end
        // any byte 2 condition is an equipment check in byte 0
        if (set2 != '0) begin
            set0[`DSE_B0_EQUIP_CHECK] = 1'b1;
        end
    end

    // sense bytes are dropped once all six have gone out
    assign clrSense = (st.send == SEND_BUSY) &&
                      (st.idx == `DSE_SENSE_LAST_IDX);

    // next state; sets always override the sense clear
    always_comb begin
        stD = st;
        if (clkEn) begin
            // three stages; a change is taken once stages 2 and 3 agree
            stD.sync1 = {eraseDriverPin, eraseGatePin, writeDriverPin,
                         writeGatePin, readGatePin, moduleSelPins,
                         headSelPins, statusPins, idxPin};
            stD.sync2 = st.sync1;
            stD.sync3 = st.sync2;
            stD.pinF  = (st.sync2 & st.sync3) |
                        ((st.sync2 ^ st.sync3) & st.pinF);
            stD.idxPrev   = st.pinF[0];
            stD.chainPrev = chainActive;
            stD.b0 = (clrSense ? `DSE_BYTE_RESET : st.b0) | set0;
            stD.b1 = (clrSense ? `DSE_BYTE_RESET : st.b1) | set1;
            stD.b2 = ((clrSense ? `DSE_BYTE_RESET : st.b2) | set2)
                   & `DSE_B2_USED_MASK;
            stD.endOp = countFieldErr;
            // chain history restarts whenever chaining lapses
            if (!chainActive) begin
                stD.maskSeen  = 1'b0;
                stD.seekSeen  = 1'b0;
                stD.writeSeen = 1'b0;
            end else if (cmdStart) begin
                stD.maskSeen  = st.maskSeen  | (cmdOp == OP_SET_MASK);
                stD.seekSeen  = st.seekSeen  | (cmdOp == OP_SEEK);
                stD.writeSeen = st.writeSeen | isWrite(cmdOp);
            end
            if (cmdStart) begin
                stD.op       = cmdOp;
                stD.mt       = cmdMultitrack;
                stD.haPassed = 1'b0;
                stD.amSeen   = 1'b0;
            end else begin
                stD.haPassed = st.haPassed | haFieldRead;
                stD.amSeen   = st.amSeen | addrMarkFound;
            end
            // flag parity history restarts with each revolution
            if (indexEdge) begin
                stD.haveFlag = 1'b0;
            end else if (flagValid) begin
                stD.haveFlag = 1'b1;
                stD.lastFlag = flagBit0;
            end
            // sense transfer: one byte per enabled cycle, bytes 0..5
            case (st.send)
                SEND_IDLE: begin
                    stD.valid = 1'b0;
                    stD.last  = 1'b0;
                    if (startSense) begin
                        stD.send = SEND_BUSY;
                        stD.idx  = 3'h0;
                    end
                end
                SEND_BUSY: begin
                    stD.valid = 1'b1;
                    stD.last  = clrSense;
                    stD.outIdx = st.idx;
                    case (st.idx)
                        3'h0:    stD.data = st.b0;
                        3'h1:    stD.data = st.b1;
                        3'h2:    stD.data = st.b2 & `DSE_B2_USED_MASK;
                        default: stD.data = `DSE_BYTE_RESET;
                    endcase
                    stD.idx = st.idx + 3'h1;
                    if (clrSense) begin
                        stD.send = SEND_IDLE;
                    end
                end
                default: begin
                    stD.send = SEND_IDLE;
                end
            endcase
        end
    end

    // state register; the enable acts in the next-state logic
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= stD;
        end
    end

    assign senseData = st.data;
    assign senseValid = st.valid;
    assign senseIndex = st.outIdx;
    assign senseLast = st.last;
    assign endOperation = st.endOp;
    assign indexPassed = ixp.latchOn;
    assign senseConditionSecondByte = st.b1;
    assign senseEquipmentThirdByte = st.b2;

    count_check_a: assert property (@(posedge clk) disable iff (reset)
        clkEn && countFieldErr |=> st.b1[`DSE_B1_COUNT_CHECK] && st.endOp)
        else $error("count check not set");
    invalid_seq_a: assert property (@(posedge clk) disable iff (reset)
        clkEn && invalidSeqHit |=> st.b1[`DSE_B1_INVALID_SEQ])
        else $error("invalid sequence not set");
    sense_last_a: assert property (@(posedge clk) disable iff (reset)
        clkEn && st.send == SEND_BUSY && st.idx == `DSE_SENSE_LAST_IDX
        |=> senseLast && senseValid)
        else $error("sixth byte not last");
endmodule

// ===== dse_cfg.svh
`ifndef DSE_CFG_SVH
`define DSE_CFG_SVH

// sense byte 0 bit positions touched by this block
`define DSE_B0_CMD_REJECT     0
`define DSE_B0_EQUIP_CHECK    3
`define DSE_B0_DATA_CHECK     4
`define DSE_B0_TRACK_COND     6
`define DSE_B0_SEEK_CHECK     7

// sense byte 1 bit positions
`define DSE_B1_COUNT_CHECK    0
`define DSE_B1_TRACK_OVERRUN  1
`define DSE_B1_END_OF_CYL     2
`define DSE_B1_INVALID_SEQ    3
`define DSE_B1_NO_RECORD      4
`define DSE_B1_FILE_PROT      5
`define DSE_B1_MISSING_AM     6
`define DSE_B1_OVF_INCOMPLETE 7

// sense byte 2 bit positions
`define DSE_B2_UNSAFE         0
`define DSE_B2_SERDES         2
`define DSE_B2_ALU            4
`define DSE_B2_UNSELECTED     5
// bits 1, 3, 6 and 7 of byte 2 always read as zero
`define DSE_B2_USED_MASK      8'h35

// sense transfer
`define DSE_SENSE_LAST_IDX    3'h5
`define DSE_BYTE_RESET        8'h00

`endif

// ===== dse_pkg.sv
package dse_pkg;

    // command currently executing, as decoded by the command logic
    typedef enum logic [4:0] {
        OP_IDLE,
        OP_READ_HA,
        OP_READ_R0,
        OP_READ_CKD,
        OP_READ_COUNT,
        OP_SEARCH_ID,
        OP_SEARCH_OTHER,
        OP_WRITE_R0,
        OP_WRITE_CKD,
        OP_WRITE_KD,
        OP_WRITE_D,
        OP_WRITE_OTHER,
        OP_SPACE_COUNT,
        OP_SENSE,
        OP_SET_MASK,
        OP_SEEK,
        OP_CONTROL
    } dse_op_e;

    // reason an overflow record could not continue
    typedef enum logic [2:0] {
        OVF_BAD_TRACK,
        OVF_FROM_ALT,
        OVF_PROTECTED,
        OVF_WRONG_HEAD,
        OVF_END_CYL
    } dse_ovf_e;

    // sense transfer sequencer
    typedef enum logic [0:0] {
        SEND_IDLE,
        SEND_BUSY
    } dse_send_e;

endpackage

// ===== dse_ixp_if.sv
// link between the sense logic and the index-passed tracker
interface dse_ixp_if;
    logic ce;         // clock enable, shared freeze
    logic indexEdge;  // one pulse per filtered index point
    logic clrLatch;   // any cause that drops the latch
    logic nrfCheck;   // single-track read or search, not exempt
    logic latchOn;    // index-passed latch
    logic nrfHit;     // index seen with latch already on

    modport host (
        output ce,
        output indexEdge,
        output clrLatch,
        output nrfCheck,
        input  latchOn,
        input  nrfHit
    );

    modport track (
        input  ce,
        input  indexEdge,
        input  clrLatch,
        input  nrfCheck,
        output latchOn,
        output nrfHit
    );
endinterface

// ===== dse_index_track.sv
module dse_index_track (
    input wire logic  clk,
    input wire logic  reset,
    dse_ixp_if.track  ixp
);
    import dse_pkg::*;

    typedef struct packed {
        logic latchOn;  // index passed since last clearing event
        logic nrfHit;   // one-cycle no-record-found pulse
    } dse_trk_s;

    dse_trk_s st;   // registered state
    dse_trk_s stD;  // next state

    // the index edge wins over a clear in the same cycle so no pass is lost
    always_comb begin
        stD = st;
        if (ixp.ce) begin
            // latch value before this index decides the hit
            stD.nrfHit = ixp.indexEdge & ixp.nrfCheck & st.latchOn;
            if (ixp.indexEdge) begin
                stD.latchOn = 1'b1;
            end else if (ixp.clrLatch) begin
                stD.latchOn = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= stD;
        end
    end

    assign ixp.latchOn = st.latchOn;
    assign ixp.nrfHit  = st.nrfHit;

    latch_set_a: assert property (@(posedge clk) disable iff (reset)
        ixp.ce && ixp.indexEdge |=> ixp.latchOn)
        else $error("index did not set the latch");

    latch_clear_a: assert property (@(posedge clk) disable iff (reset)
        ixp.ce && ixp.clrLatch && !ixp.indexEdge |=> !ixp.latchOn)
        else $error("index latch not cleared");

    nrf_pulse_a: assert property (@(posedge clk) disable iff (reset)
        ixp.ce && ixp.indexEdge && ixp.nrfCheck && ixp.latchOn
        |=> ixp.nrfHit)
        else $error("second index did not flag no record");
endmodule

// ===== dse_drive_model.sv
// behavioural disk drive seen by the sense logic: index point,
// selection lines and gate/driver pairs, with commanded faults
module dse_drive_model (
    input  wire logic       clk,
    input  wire logic       idxReq,
    input  wire logic [1:0] fault,
    output logic            idxPin,
    output logic [7:0]      statusPins,
    output logic [9:0]      headSelPins,
    output logic [7:0]      moduleSelPins,
    output logic            readGatePin,
    output logic            writeGatePin,
    output logic            writeDriverPin,
    output logic            eraseGatePin,
    output logic            eraseDriverPin
);
    timeunit 1ns;
    timeprecision 1ns;

    // index follows the request one edge late, like a real sensor
    always_ff @(posedge clk) begin
        idxPin <= idxReq;
    end

    // fault 1: two heads, 2: stray status unselected, 3: gate mismatch
    always_comb begin
        headSelPins    = (fault == 2'h1) ? 10'h003 : 10'h001;
        moduleSelPins  = (fault == 2'h2) ? 8'h00 : 8'h01;
        statusPins     = (fault == 2'h2) ? 8'h04 : 8'h00;
        writeGatePin   = (fault == 2'h3);
        writeDriverPin = 1'b0;
        readGatePin    = 1'b0;
        eraseGatePin   = 1'b0;
        eraseDriverPin = 1'b0;
    end
endmodule

// ===== tb_dse_sense_top.sv
module tb_dse_sense_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dse_pkg::*;

    logic clk = 0, reset = 1, clkEn = 1, cmdStart = 0, cmdMultitrack = 0;
    logic chainActive = 0, countFieldErr = 0, writeActive = 0;
    logic endOfCylHit = 0, headSwitchReq = 0, invalidSeqHit = 0;
    logic haFieldRead = 0, dataFieldRead = 0, addrMarkFound = 0;
    logic haR0Missing = 0, maskViolation = 0, maskWriteViol = 0;
    logic flagValid = 0, flagBit0 = 0, ovfEvent = 0, serdesErr = 0;
    logic aluErr = 0, idxReq = 0;
    logic [1:0] fault = 2'h0;
    dse_op_e    cmdOp = OP_IDLE;
    dse_ovf_e   ovfCause = OVF_BAD_TRACK;
    logic idxPin, readGatePin, writeGatePin, writeDriverPin;
    logic eraseGatePin, eraseDriverPin, senseValid, senseLast;
    logic endOperation, indexPassed;
    logic [7:0] statusPins, moduleSelPins, senseData;
    logic [7:0] senseConditionSecondByte, senseEquipmentThirdByte;
    logic [9:0] headSelPins;
    logic [2:0] senseIndex;
    wire  [15:0] sb = {senseEquipmentThirdByte, senseConditionSecondByte};
    int miscompares = 0, num_checks = 0, endOps = 0;

    always #25 clk = ~clk;
    // count end-of-operation pulses; they may be a single cycle
    always @(negedge clk) if (endOperation === 1'b1) endOps++;

    dse_sense_top dse_sense_top_i (.clk, .reset, .clkEn, .cmdStart,
        .cmdOp, .cmdMultitrack, .chainActive, .countFieldErr,
        .writeActive, .endOfCylHit, .headSwitchReq, .invalidSeqHit,
        .haFieldRead, .dataFieldRead, .addrMarkFound, .haR0Missing,
        .maskViolation, .maskWriteViol, .flagValid, .flagBit0,
        .ovfEvent, .ovfCause, .serdesErr, .aluErr, .idxPin,
        .statusPins, .headSelPins, .moduleSelPins, .readGatePin,
        .writeGatePin, .writeDriverPin, .eraseGatePin, .eraseDriverPin,
        .senseData, .senseValid, .senseIndex, .senseLast, .endOperation,
        .indexPassed, .senseConditionSecondByte, .senseEquipmentThirdByte);

    dse_drive_model dse_drive_model_i (.clk, .idxReq, .fault, .idxPin,
        .statusPins, .headSelPins, .moduleSelPins, .readGatePin,
        .writeGatePin, .writeDriverPin, .eraseGatePin, .eraseDriverPin);

    // byte compare
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    // single flag compare
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // one-cycle strobe, then a quiet cycle so a next call never
    // raises it in the time step that lowered it
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge clk);
        s = 0;
        @(negedge clk);
    endtask

    // sense bits are sticky, so a bounded wait then one compare
    task automatic waitSet(input int i);
        for (int n = 0; n < 40 && sb[i] !== 1'b1; n++) @(negedge clk);
        chk1(sb[i], 1'b1);
    endtask

    task automatic stayClear(input int i);
        repeat (30) @(negedge clk);
        chk1(sb[i], 1'b0);
    endtask

    // synchronous reset also clears all sticky sense bits
    task automatic rst;
        reset = 1;
        chainActive = 0;
        fault = 2'h0;
        repeat (8) @(negedge clk);
        reset = 0;
    endtask

    task automatic start(input dse_op_e op);
        cmdOp = op;
        pulse(cmdStart);
    endtask

    // one index point from the drive, then a quiet stretch
    task automatic idx;
        idxReq = 1;
        repeat (4) @(negedge clk);
        idxReq = 0;
        repeat (12) @(negedge clk);
    endtask

    task automatic flag(input logic b);
        flagBit0 = b;
        pulse(flagValid);
        repeat (3) @(negedge clk);
    endtask

    task automatic t_basic;
        int e0;
        chk8(senseConditionSecondByte, 8'h00);
        chk8(senseEquipmentThirdByte, 8'h00);
        start(OP_READ_COUNT);
        e0 = endOps;
        pulse(countFieldErr);
        waitSet(0);
        chk1(endOps > e0, 1'b1);
        rst;
        start(OP_WRITE_CKD);
        writeActive = 1;
        idx;
        waitSet(1);
        rst;
        start(OP_READ_CKD);
        idx;
        stayClear(1);
        writeActive = 0;
        $display("test basic done");
    endtask

    task automatic t_chain;
        rst;
        chainActive = 1;
        pulse(endOfCylHit);
        waitSet(2);
        pulse(headSwitchReq);
        waitSet(3);
        start(OP_SEEK);
        pulse(maskViolation);
        waitSet(5);
        rst;
        chainActive = 1;
        start(OP_SET_MASK);
        start(OP_SET_MASK);
        waitSet(3);
        rst;
        chainActive = 1;
        start(OP_WRITE_D);
        start(OP_SPACE_COUNT);
        waitSet(3);
        cmdMultitrack = 1;
        start(OP_SEARCH_OTHER);
        cmdMultitrack = 0;
        pulse(maskViolation);
        waitSet(5);
        $display("test chain done");
    endtask

    task automatic t_index;
        rst;
        chainActive = 1;
        start(OP_SEARCH_ID);
        idx;
        chk1(indexPassed, 1'b1);
        pulse(haFieldRead);
        repeat (4) @(negedge clk);
        chk1(indexPassed, 1'b0);
        idx;
        pulse(dataFieldRead);
        repeat (4) @(negedge clk);
        chk1(indexPassed, 1'b0);
        idx;
        idx;
        waitSet(4);
        rst;
        chainActive = 1;
        start(OP_SEARCH_ID);
        idx;
        chainActive = 0;
        repeat (4) @(negedge clk);
        chk1(indexPassed, 1'b0);
        rst;
        chainActive = 1;
        start(OP_READ_HA);
        idx;
        idx;
        stayClear(4);
        $display("test index done");
    endtask

    task automatic t_mark;
        rst;
        start(OP_READ_CKD);
        flag(1'b0);
        flag(1'b0);
        waitSet(6);
        rst;
        start(OP_SEARCH_ID);
        flag(1'b0);
        flag(1'b0);
        stayClear(6);
        rst;
        pulse(haR0Missing);
        waitSet(4);
        for (int c = 0; c < 5; c++) begin
            rst;
            ovfCause = dse_ovf_e'(c);
            pulse(ovfEvent);
            waitSet(7);
            if (ovfCause == OVF_END_CYL) waitSet(2);
            if (ovfCause == OVF_PROTECTED) waitSet(5);
        end
        $display("test mark done");
    endtask

    task automatic t_equip;
        for (int f = 1; f < 4; f++) begin
            rst;
            fault = 2'(f);
            waitSet(f == 2 ? 13 : 8);
        end
        rst;
        clkEn = 0;
        pulse(aluErr);
        stayClear(12);
        clkEn = 1;
        pulse(serdesErr);
        waitSet(10);
        pulse(aluErr);
        waitSet(12);
        chk8(senseEquipmentThirdByte & 8'hca, 8'h00);
        $display("test equip done");
    endtask

    task automatic t_sense;
        int n;
        rst;
        pulse(invalidSeqHit);
        waitSet(3);
        start(OP_SENSE);
        n = 0;
        for (int k = 0; k < 80 && n < 6; k++) begin
            if (senseValid === 1'b1) begin
                chk8({5'h00, senseIndex}, 8'(n));
                chk8(senseData, (n == 1) ? 8'h08 : 8'(n == 0));
                n++;
                chk1(senseLast, n == 6);
            end
            @(negedge clk);
        end
        chk8(8'(n), 8'h06);
        $display("test sense done");
    endtask

    // the one place the run ends
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        @(negedge clk);
        rst;
        t_basic;
        t_chain;
        t_index;
        t_mark;
        t_equip;
        t_sense;
        conclude;
    end
endmodule
